// File: src/ftot_pkg.sv
// Package: constants and types for the flow totalizer
package ftot_pkg;
  // ********************************************************************
  // Widths and limits
  // ********************************************************************
  localparam int unsigned CNT_W = 20;
  localparam logic [19:0] CNT_MAX = 20'hf423f;  // 999999
  localparam logic [19:0] CNT_ZERO = 20'h00000;
  localparam logic [19:0] CNT_WRAP_TO = 20'h00001;
  localparam int unsigned FLOW_W = 24;
  localparam int unsigned FRAC_W = 32;
  // Fixed point: divisors carry 4 fraction digits (x10000)
  localparam logic [31:0] DIV_ONE = 32'h00002710;
  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam int unsigned PULSE_MIN_MS = 200;
  localparam int unsigned PULSE_MIN_TICKS = PULSE_MIN_MS / TICK_MS;
  localparam int unsigned HALF_MIN_TICKS = PULSE_MIN_TICKS / 2;
  // ********************************************************************
  // Unit classes of the input channel
  // ********************************************************************
  localparam logic [1:0] UNIT_NONE = 2'h0;
  localparam logic [1:0] UNIT_VOL = 2'h1;
  localparam logic [1:0] UNIT_MASS = 2'h2;
  localparam logic [1:0] UNIT_OTHER = 2'h3;
  // ********************************************************************
  // Run state
  // ********************************************************************
  typedef enum logic [2:0] {
    FTOT_OFF = 3'b001,
    FTOT_STOP = 3'b010,
    FTOT_RUN = 3'b100
  } ftot_state_t;
endpackage : ftot_pkg

// File: src/ftot_step_if.sv
// Interface: step events from the integrator to the pulse generator
`timescale 1ns/10ps
interface ftot_step_if;
  logic tick;
  logic run;
  logic clear;
  logic [31:0] frac_inc;
  modport src (output tick, output run, output clear, output frac_inc);
  modport dst (input tick, input run, input clear, input frac_inc);
endinterface : ftot_step_if

// File: src/ftot_pulse.sv
// Module: scaled pulse output with half-period duty and rate limit
`timescale 1ns/10ps
module ftot_pulse
#(
  parameter int unsigned ACC_W = 32
)
(
  input wire logic ref_clk,  // Clock
  input wire logic rst_n,  // Sync reset
  ftot_step_if.dst step,  // Step events
  input wire logic [31:0] pulse_divisor,  // Divisor x10000
  input wire logic restore,  // Load restored level
  input wire logic restore_val,  // Restored level
  output logic pulse  // Pulse level
);
  logic [ACC_W-1:0] acc_q, acc_d;
  logic pulse_q, pulse_d;
  logic [3:0] age_q, age_d;

  // ********************************************************************
  // Phase accumulator: on at each full divisor, off halfway
  // ********************************************************************
  always_comb
  begin
    logic [ACC_W:0] sum;
    sum = '0;
    acc_d = acc_q;
    pulse_d = pulse_q;
    age_d = age_q;
    if (step.clear)
    begin
      acc_d = '0;
      pulse_d = 1'b0;
      age_d = 4'h0;
    end
    else if (restore)
    begin
      pulse_d = restore_val;
    end
    else if (step.tick && step.run)
    begin
      sum = {1'b0, acc_q} + {1'b0, step.frac_inc};
      acc_d = sum[ACC_W-1:0];
      if (age_q != 4'hf)
        age_d = age_q + 4'h1;
      // Min on/off time keeps period >= 200 ms
      if (age_q >= 4'(ftot_pkg::HALF_MIN_TICKS - 1))  // R15
      begin
        if (!pulse_q && sum[ACC_W-1:0] >= pulse_divisor)
        begin
          acc_d = ACC_W'(sum[ACC_W-1:0] - pulse_divisor);  // R13
          pulse_d = 1'b1;
          age_d = 4'h0;
        end
        else if (pulse_q && sum[ACC_W-1:0] >= (pulse_divisor >> 1))
        begin
          pulse_d = 1'b0;  // R13
          age_d = 4'h0;
        end
      end
      // Pulses beyond the rate limit are dropped so the phase stays bounded
      if (acc_d >= pulse_divisor && pulse_divisor != 32'h0)  // R15
        acc_d = ACC_W'(pulse_divisor - 32'h1);
    end
  end

  // Register stage; held while stopped
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      acc_q <= '0;
      pulse_q <= 1'b0;
      age_q <= 4'hf;
    end
    else
    begin
      acc_q <= acc_d;  // R4
      pulse_q <= pulse_d;
      age_q <= age_d;
    end
  end

  assign pulse = pulse_q;
endmodule : ftot_pulse

// File: src/ftot_top.sv
// Module: flow totalizer, batch and run totals, pulse and threshold outputs
//
// Behaviour
// [R1] One totalizer per input; only flow or unitless inputs are totalized.
// [R2] Run clear also clears elapsed time and batch; run clear needs tune level.
// [R3] Disabled: pulse and both threshold outputs forced off.
// [R4] Enabled but stopped: pulse and threshold outputs hold last state.
// [R5] Warm start with restore set reloads saved totals and outputs.
// [R6] Cold start, or warm start without restore, zeros totals and outputs.
// [R7] Up with wrap: 999999 steps to 1.
// [R8] Up without wrap: saturate at 999999.
// [R9] Down: stop at zero always.
// [R10] Count divisor scales count rate against input timebase.
// [R11] Any clear loads the initial count value.
// [R12] No accumulation while input below low-flow cutoff.
// [R13] Pulse on every pulse-divisor counts, off halfway to next.
// [R14] Totalizer updates once per 100 ms tick.
// [R15] Pulse period at least 200 ms.
// [R16] Count-up select picks up or down from initial value.
// [R17] Down counting forces wrap off.
// [R18] Up: threshold output on while count above threshold.
// [R19] Down: threshold output on while count below threshold.
// [R20] Two independent threshold outputs.
// [R21] Start only when enabled; disabled ignores start.
// [R22] Fractional accumulator keeps residue, one step per whole unit.
`timescale 1ns/10ps
module ftot_top
#(
  parameter int unsigned TICK_CYCLES = ftot_pkg::TICK_CYC
)
(
  input wire logic ref_clk,  // 250 MHz clock
  input wire logic rst_n,  // Sync reset, low
  input wire logic warm_start,  // High: warm start at reset release
  input wire logic restore_on_warm_start,  // Restore option
  input wire logic [19:0] saved_count,  // Saved batch count
  input wire logic [19:0] saved_run,  // Saved run count
  input wire logic saved_pulse,  // Saved pulse level
  input wire logic [1:0] saved_thresh,  // Saved threshold levels
  input wire logic [1:0] unit_class,  // Input unit class
  input wire logic [23:0] flow_in,  // Scaled flow, units/tick x10000
  input wire logic [23:0] low_flow_cutoff,  // Cutoff
  input wire logic [31:0] count_divisor,  // Divisor x10000
  input wire logic [31:0] pulse_divisor,  // Divisor x10000
  input wire logic [19:0] init_value,  // Initial count
  input wire logic [19:0] thresh1,  // Threshold 1
  input wire logic [19:0] thresh2,  // Threshold 2
  input wire logic wrap_sel,  // Wrap option
  input wire logic count_up_select,  // High counts up
  input wire logic enable,  // Totalizer enable
  input wire logic start_cmd,  // Start pulse
  input wire logic stop_cmd,  // Stop pulse
  input wire logic clr_batch,  // Batch clear pulse
  input wire logic clr_run,  // Run clear pulse
  input wire logic [1:0] access_level,  // 0 operator .. 3
  output logic [19:0] batch_accumulator,  // Batch_accumulator
  output logic [19:0] run_total,  // Run total
  output logic [31:0] run_elapsed_time,  // Run ticks
  output logic pulse_out,  // Pulse output
  output logic [1:0] thresh_out,  // Threshold outputs
  output logic not_totalizable,  // Input units invalid
  output logic running  // Running state
);
  localparam logic [1:0] TUNE_LEVEL = 2'h1;

  ftot_step_if step ();

  ftot_pkg::ftot_state_t st_q, st_d;
  logic [31:0] tcnt_q, tcnt_d;
  logic tick;
  logic [19:0] bat_q, bat_d, run_q, run_d;
  logic [31:0] time_q, time_d;
  logic [31:0] frac_q, frac_d;
  logic [1:0] th_q, th_d;
  logic init_q, init_d;
  logic restore_now;
  logic pulse_w;
  logic ok_units;
  logic wrap_eff;
  logic clr_all;
  logic clr_b;

  // ********************************************************************
  // Helpers
  // ********************************************************************
  // Several count steps at once with wrap and limits
  function automatic logic [19:0] ftot_step(input logic [19:0] v, input logic [32:0] n,
                                            input logic up, input logic wrap);
    logic [33:0] t;
    logic [19:0] r;
    t = {14'h0, v} + {1'b0, n};
    r = v;
    if (up)
    begin
      if (t <= {14'h0, ftot_pkg::CNT_MAX})
        r = t[19:0];
      else if (wrap)
        r = 20'((t - 34'h1) % {14'h0, ftot_pkg::CNT_MAX}) + ftot_pkg::CNT_WRAP_TO;  // R7
      else
        r = ftot_pkg::CNT_MAX;  // R8
    end
    else if ({13'h0, v} > n)
      r = v - n[19:0];
    else
      r = ftot_pkg::CNT_ZERO;  // R9
    return r;
  endfunction : ftot_step

  // Threshold comparison per direction
  function automatic logic ftot_cmp(input logic [19:0] v, input logic [19:0] t,
                                    input logic up);
    return up ? (v > t) : (v < t);  // R18 R19
  endfunction : ftot_cmp

  // ********************************************************************
  // Decode
  // ********************************************************************
  assign ok_units = (unit_class != ftot_pkg::UNIT_OTHER);  // R1
  assign wrap_eff = wrap_sel & count_up_select;  // R17
  assign clr_all = clr_run && (access_level >= TUNE_LEVEL);  // R2
  assign clr_b = clr_batch || clr_all;
  assign tick = (tcnt_q == TICK_CYCLES - 1);  // R14
  assign restore_now = init_q && warm_start && restore_on_warm_start;

  // ********************************************************************
  // Tick divider
  // ********************************************************************
  always_comb
  begin
    tcnt_d = tick ? 32'h0 : tcnt_q + 32'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      tcnt_q <= 32'h0;
    else
      tcnt_q <= tcnt_d;
  end

  // ********************************************************************
  // Run state machine
  // ********************************************************************
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ftot_pkg::FTOT_OFF:
        if (enable)
          st_d = ftot_pkg::FTOT_STOP;
      ftot_pkg::FTOT_STOP:
        if (!enable)
          st_d = ftot_pkg::FTOT_OFF;
        else if (start_cmd && ok_units)
          st_d = ftot_pkg::FTOT_RUN;  // R21
      ftot_pkg::FTOT_RUN:
        if (!enable)
          st_d = ftot_pkg::FTOT_OFF;
        else if (stop_cmd || !ok_units)
          st_d = ftot_pkg::FTOT_STOP;
      default:
        st_d = ftot_pkg::FTOT_OFF;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      st_q <= ftot_pkg::FTOT_OFF;
    else
      st_q <= st_d;
  end

  // ********************************************************************
  // Integrator and totals
  // ********************************************************************
  always_comb
  begin
    logic [32:0] sum;
    logic [32:0] nstep;
    sum = '0;
    nstep = '0;
    bat_d = bat_q;
    run_d = run_q;
    time_d = time_q;
    frac_d = frac_q;
    th_d = th_q;
    init_d = 1'b0;
    step.frac_inc = {8'h00, flow_in};
    if (init_q)
    begin
      if (restore_now)
      begin
        bat_d = saved_count;  // R5
        run_d = saved_run;
        th_d = saved_thresh;
      end
      else
      begin
        bat_d = ftot_pkg::CNT_ZERO;  // R6
        run_d = ftot_pkg::CNT_ZERO;
        th_d = 2'b00;
      end
    end
    else
    begin
      if (clr_b)
      begin
        bat_d = init_value;  // R11
        frac_d = 32'h0;
      end
      if (clr_all)
      begin
        run_d = init_value;  // R2 R11
        time_d = 32'h0;
      end
      if (!clr_b && tick && st_q == ftot_pkg::FTOT_RUN)
      begin
        time_d = time_q + 32'h1;
        if (flow_in >= low_flow_cutoff && count_divisor != 32'h0)  // R12
        begin
          // Whole divisor units step the count, the residue waits for later ticks
          sum = {1'b0, frac_q} + {9'h000, flow_in};  // R22
          nstep = sum / {1'b0, count_divisor};  // R10
          frac_d = 32'(sum % {1'b0, count_divisor});
          bat_d = ftot_step(bat_q, nstep, count_up_select, wrap_eff);  // R16
          run_d = ftot_step(run_q, nstep, count_up_select, wrap_eff);
        end
      end
      // Thresholds follow count only while running
      if (st_q == ftot_pkg::FTOT_RUN)
      begin
        for (int i = 0; i < 2; i++)  // R20
          th_d[i] = ftot_cmp(bat_d, i == 0 ? thresh1 : thresh2, count_up_select);
      end
    end
    // Restored levels survive the start-up cycle in which the state is still off
    if (st_q == ftot_pkg::FTOT_OFF && !init_q)
      th_d = 2'b00;  // R3
    if (flow_in < low_flow_cutoff)
      step.frac_inc = 32'h0;  // R12
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      bat_q <= ftot_pkg::CNT_ZERO;
      run_q <= ftot_pkg::CNT_ZERO;
      time_q <= 32'h0;
      frac_q <= 32'h0;
      th_q <= 2'b00;
      init_q <= 1'b1;
    end
    else
    begin
      bat_q <= bat_d;
      run_q <= run_d;
      time_q <= time_d;
      frac_q <= frac_d;
      th_q <= th_d;  // R4
      init_q <= init_d;
    end
  end

  // ********************************************************************
  // Pulse generator
  // ********************************************************************
  assign step.tick = tick;
  assign step.run = (st_q == ftot_pkg::FTOT_RUN);
  assign step.clear = ((st_q == ftot_pkg::FTOT_OFF) && !init_q) || (init_q && !restore_now);  // R3 R6

  ftot_pulse #(.ACC_W(32)) u_pulse (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(step),
    .pulse_divisor(pulse_divisor),
    .restore(restore_now),
    .restore_val(saved_pulse),
    .pulse(pulse_w)
  );

  // ********************************************************************
  // Output registers
  // ********************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      batch_accumulator <= 20'h00000;
      run_total <= 20'h00000;
      run_elapsed_time <= 32'h0;
      pulse_out <= 1'b0;
      thresh_out <= 2'b00;
      not_totalizable <= 1'b0;
      running <= 1'b0;
    end
    else
    begin
      batch_accumulator <= bat_q;
      run_total <= run_q;
      run_elapsed_time <= time_q;
      pulse_out <= pulse_w && (st_q != ftot_pkg::FTOT_OFF);  // R3
      thresh_out <= th_q;
      not_totalizable <= !ok_units;  // R1
      running <= (st_q == ftot_pkg::FTOT_RUN);
    end
  end
endmodule : ftot_top

// File: testbench/ftot_chk_sva.sv
// Checker: output relations of the flow totalizer
`timescale 1ns/10ps
module ftot_chk
#(
  parameter int unsigned TICK_CYCLES = 50
)
(
  input wire logic ref_clk,  // Clock
  input wire logic rst_n,  // Reset
  input wire logic warm_start,  // Warm start
  input wire logic restore_on_warm_start,  // Restore
  input wire logic [19:0] saved_count,  // Saved count
  input wire logic [19:0] init_value,  // Initial
  input wire logic [19:0] thresh1,  // Threshold 1
  input wire logic [19:0] thresh2,  // Threshold 2
  input wire logic wrap_sel,  // Wrap
  input wire logic count_up_select,  // Up
  input wire logic enable,  // Enable
  input wire logic start_cmd,  // Start
  input wire logic clr_batch,  // Batch clear
  input wire logic clr_run,  // Run clear
  input wire logic [1:0] access_level,  // Access
  input wire logic [19:0] batch_accumulator,  // Batch
  input wire logic [19:0] run_total,  // Run
  input wire logic [31:0] run_elapsed_time,  // Elapsed
  input wire logic pulse_out,  // Pulse
  input wire logic [1:0] thresh_out,  // Thresholds
  input wire logic running  // Run state
);
  logic pulse_q;
  logic pulse_d;
  logic [31:0] gap_q;
  logic [31:0] gap_d;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Cycles since last pulse edge, parked at top while not counting
  always_comb
  begin
    pulse_d = pulse_out;
    gap_d = (gap_q == 32'hffffffff) ? gap_q : gap_q + 32'h1;
    if (pulse_out != pulse_q)
      gap_d = 32'h0;
    if (!enable || !running || clr_batch || clr_run)
      gap_d = 32'hffffffff;
  end
  // Helper registers
  always_ff @(posedge ref_clk)
  begin
    pulse_q <= rst_n ? pulse_d : 1'b0;
    gap_q <= rst_n ? gap_d : 32'hffffffff;
  end
  property p_off; (!enable) [*3] |=> !pulse_out && thresh_out == 2'h0; endproperty
  a_off: assert property (p_off) else $error("outputs on while disabled");
  property p_idle; (!enable) [*3] |=> !running; endproperty
  a_idle: assert property (p_idle) else $error("running while disabled");
  property p_hold; (enable && !running && !start_cmd && !clr_batch && !clr_run) [*6]
    |=> $stable(pulse_out) && $stable(thresh_out); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved while stopped");
  property p_sat; (count_up_select && !wrap_sel && !clr_batch && !clr_run) [*4]
    ##0 $past(batch_accumulator) == ftot_pkg::CNT_MAX |-> batch_accumulator == ftot_pkg::CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("count left upper limit");
  property p_floor; (!count_up_select && !clr_batch && !clr_run) [*4]
    ##0 $past(batch_accumulator) == 20'h0 |-> batch_accumulator == 20'h0; endproperty
  a_floor: assert property (p_floor) else $error("down count left zero");
  property p_clr; clr_run && access_level != 2'h0 && !running |-> ##3 run_elapsed_time == 32'h0
    && batch_accumulator == init_value && run_total == init_value; endproperty
  a_clr: assert property (p_clr) else $error("run clear incomplete");
  property p_deny; clr_run && access_level == 2'h0 && !running ##1 (!clr_run) [*2]
    |=> run_total == $past(run_total, 3); endproperty
  a_deny: assert property (p_deny) else $error("run clear at operator level");
  property p_gap; pulse_out != pulse_q |-> gap_q >= TICK_CYCLES - 1; endproperty
  a_gap: assert property (p_gap) else $error("pulse edge too soon");
  property p_thr; enable [*3] ##0 (running && $changed(thresh_out)) |-> thresh_out == (count_up_select
    ? {batch_accumulator > thresh2, batch_accumulator > thresh1}
    : {batch_accumulator < thresh2, batch_accumulator < thresh1}); endproperty
  a_thr: assert property (p_thr) else $error("threshold output wrong");
  property p_warm; $rose(rst_n) && warm_start && restore_on_warm_start
    |-> ##4 batch_accumulator == saved_count; endproperty
  a_warm: assert property (p_warm) else $error("count not restored");
endmodule : ftot_chk

bind ftot_top ftot_chk #(.TICK_CYCLES(TICK_CYCLES)) ftot_chk_i (.ref_clk, .rst_n, .warm_start,
  .restore_on_warm_start, .saved_count, .init_value, .thresh1, .thresh2, .wrap_sel,
  .count_up_select, .enable, .start_cmd, .clr_batch, .clr_run, .access_level,
  .batch_accumulator, .run_total, .run_elapsed_time, .pulse_out, .thresh_out, .running);

// File: testbench/ftot_flow_model.sv
// Partner: analog flow channel and discrete output receiver
`timescale 1ns/10ps
module ftot_flow_model
(
  input wire logic ref_clk,  // Clock
  input wire logic [23:0] flow_set,  // Requested flow
  input wire logic [1:0] unit_set,  // Requested units
  input wire logic pulse_out,  // Pulse from block
  output logic [23:0] flow_in,  // Flow reading
  output logic [1:0] unit_class,  // Unit class
  output int hi_len,  // Last high phase
  output int lo_len  // Last low phase
);
  int run_len = 0;
  logic last = 1'b0;
  // Channel reading follows the bench, changed after falling edges
  assign flow_in = flow_set;
  assign unit_class = unit_set;
  // Phase lengths of the pulse in cycles
  always @(posedge ref_clk)
  begin
    run_len <= (pulse_out == last) ? run_len + 1 : 1;
    last <= pulse_out;
    if (pulse_out != last && last)
      hi_len <= run_len;
    if (pulse_out != last && !last)
      lo_len <= run_len;
  end
endmodule : ftot_flow_model

// File: testbench/test_ftot_top.sv
// Testbench: flow totalizer against an integer model
`timescale 1ns/10ps
module test_ftot_top;
  logic ref_clk;
  logic rst_n;
  logic warm_start;
  logic restore_on_warm_start;
  logic [19:0] saved_count;
  logic [19:0] saved_run;
  logic saved_pulse;
  logic [1:0] saved_thresh;
  logic [1:0] unit_class;
  logic [1:0] unit_set;
  logic [23:0] flow_in;
  logic [23:0] flow_set;
  logic [23:0] low_flow_cutoff;
  logic [31:0] count_divisor;
  logic [31:0] pulse_divisor;
  logic [19:0] init_value;
  logic [19:0] thresh1;
  logic [19:0] thresh2;
  logic wrap_sel;
  logic count_up_select;
  logic enable;
  logic [3:0] cmd;
  logic [1:0] access_level;
  logic [19:0] batch_accumulator;
  logic [19:0] run_total;
  logic [31:0] run_elapsed_time;
  logic pulse_out;
  logic [1:0] thresh_out;
  logic not_totalizable;
  logic running;
  int hi_len;
  int lo_len;
  int errors = 0;
  int compares = 0;
  int seed;
  int m_b;
  int m_r;
  int m_t;
  int frac;
  int i;
  ftot_top #(.TICK_CYCLES(50)) ftot_top_i (.ref_clk, .rst_n, .warm_start,
    .restore_on_warm_start, .saved_count, .saved_run, .saved_pulse, .saved_thresh,
    .unit_class, .flow_in, .low_flow_cutoff, .count_divisor, .pulse_divisor, .init_value,
    .thresh1, .thresh2, .wrap_sel, .count_up_select, .enable, .start_cmd(cmd[0]),
    .stop_cmd(cmd[1]), .clr_batch(cmd[2]), .clr_run(cmd[3]), .access_level,
    .batch_accumulator, .run_total, .run_elapsed_time, .pulse_out, .thresh_out,
    .not_totalizable, .running);
  ftot_flow_model ftot_flow_model_i (.ref_clk, .flow_set, .unit_set, .pulse_out, .flow_in,
    .unit_class, .hi_len, .lo_len);
  // Clock, 4 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    results();
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  // One-cycle command: 0 start, 1 stop, 2 batch clear, 3 run clear
  task automatic go(input int k);
    cmd = 4'h1 << k;
    cyc(1);
    cmd = 4'h0;
  endtask : go
  task automatic do_reset();
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
    cyc(8);
  endtask : do_reset
  function automatic int step(input int v);
    if (!count_up_select)
      return (v > 0) ? v - 1 : 0;
    if (v == 999999)
      return wrap_sel ? 1 : v;
    return v + 1;
  endfunction : step
  task automatic check_all();
    chk("batch", m_b, batch_accumulator);
    chk("run", m_r, run_total);
    chk("elapsed", m_t, run_elapsed_time);
  endtask : check_all
  task automatic clear_run();
    access_level = 2'h1;
    go(3);
    cyc(4);
    {m_b, m_r, m_t, frac} = {12'h0, init_value, 12'h0, init_value, 64'h0};
    check_all();
  endtask : clear_run
  // Count for exactly k ticks, then compare with the model
  task automatic run_ticks(input int k);
    go(0);
    // Start and stop edges bound exactly k*50 running cycles, so k ticks
    cyc(k * 50 - 1);
    go(1);
    cyc(4);
    repeat (k)
    begin
      m_t++;
      if (flow_set >= low_flow_cutoff)
        frac += flow_set;
      while (frac >= count_divisor)
      begin
        frac -= count_divisor;
        m_b = step(m_b);
        m_r = step(m_r);
      end
    end
    check_all();
    chk("thresh", count_up_select ? {m_b > thresh2, m_b > thresh1}
      : {m_b < thresh2, m_b < thresh1}, thresh_out);
  endtask : run_ticks
  task automatic results();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // Main sequence
  initial
  begin
    seed = 15274;
    {rst_n, warm_start, restore_on_warm_start, saved_pulse, wrap_sel, cmd} = 9'h0;
    {saved_count, saved_run, saved_thresh, init_value, thresh1} = 82'h0;
    {enable, count_up_select, unit_set, access_level} = 6'h35;
    {flow_set, low_flow_cutoff} = {24'h0, 24'h0003e8};
    {count_divisor, pulse_divisor} = {ftot_pkg::DIV_ONE, 32'h00009c40};
    thresh2 = 20'hfffff;
    do_reset();
    for (i = 0; i < 4; i++)
    begin
      unit_set = i[1:0];
      cyc(2);
      go(0);
      cyc(4);
      chk("units", i == 3, not_totalizable);
      chk("running", i != 3, running);
      go(1);
      cyc(4);
    end
    unit_set = 2'h1;
    for (i = 0; i < 3; i++)
    begin
      count_divisor = (i == 0) ? 32'h2710 : (i == 1) ? 32'h186a0 : 32'h3e8;
      flow_set = 24'h001388 + ($random(seed) & 24'h003fff);
      init_value = $random(seed) & 20'h003ff;
      thresh1 = init_value + 20'h3;
      clear_run();
      run_ticks(8);
    end
    for (i = 0; i < 2; i++)
    begin
      flow_set = low_flow_cutoff - 24'h1 + i;
      run_ticks(4);
    end
    access_level = 2'h0;
    go(3);
    cyc(4);
    check_all();
    go(2);
    cyc(4);
    m_b = init_value;
    check_all();
    count_divisor = ftot_pkg::DIV_ONE;
    flow_set = 24'h007530;
    init_value = 20'hf423d;
    for (i = 0; i < 2; i++)
    begin
      wrap_sel = i[0];
      clear_run();
      run_ticks(1);
    end
    {count_up_select, init_value, thresh1, thresh2} = {1'b0, 20'h5, 20'h3, 20'h1};
    clear_run();
    run_ticks(1);
    run_ticks(1);
    {count_up_select, wrap_sel, init_value, thresh1, thresh2} = {2'h2, 20'h0, 20'h2, 20'hfffff};
    flow_set = 24'h002710;
    clear_run();
    go(0);
    cyc(700);
    chk("pulse_hi", pulse_divisor / flow_set * 25, hi_len);
    chk("pulse_lo", pulse_divisor / flow_set * 25, lo_len);
    pulse_divisor = 32'h000003e8;
    cyc(300);
    chk("pulse_min", 1, hi_len == 50 && lo_len == 50);
    go(1);
    cyc(4);
    chk("thresh", 2'h1, thresh_out);
    enable = 1'b0;
    cyc(4);
    chk("off", 3'h0, {pulse_out, thresh_out});
    go(0);
    cyc(4);
    chk("running", 0, running);
    enable = 1'b1;
    {saved_pulse, saved_thresh} = 3'h6;
    for (i = 0; i < 3; i++)
    begin
      saved_count = $random(seed) & 20'h7ffff;
      saved_run = $random(seed) & 20'h7ffff;
      {warm_start, restore_on_warm_start} = {i != 2, i == 0};
      do_reset();
      chk("batch", (i == 0) ? saved_count : 0, batch_accumulator);
      chk("run", (i == 0) ? saved_run : 0, run_total);
      chk("outs", (i == 0) ? 3'h6 : 3'h0, {pulse_out, thresh_out});
    end
    results();
  end
endmodule : test_ftot_top
